// File: shared/wrr_sched_regs.vh
// Register offsets, field layout, reset values and sizes of the weighted round-robin scheduler.
`ifndef WRR_SCHED_REGS_VH
`define WRR_SCHED_REGS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define WRR_OFF_ENTRIES_0_3   12'h7E0
`define WRR_OFF_ENTRIES_4_7   12'h7E4
`define WRR_OFF_ENTRIES_8_11  12'h7E8
`define WRR_OFF_ENTRIES_12_15 12'h7EC
`define WRR_OFF_STATUS        12'h7F0
`define WRR_ADDR_W            12

// ==========================================================================
// Field layout of one schedule entry byte
// ==========================================================================
`define WRR_ENTRY_W           8
`define WRR_QSEL_LSB          0
`define WRR_QSEL_W            4
`define WRR_COUNT_LSB         4
`define WRR_COUNT_W           4
`define WRR_NUM_ENTRIES       16
`define WRR_NUM_QUEUES        16

// ==========================================================================
// Reset values and bus answers
// ==========================================================================
`define WRR_COUNT_RESET       4'h0
`define WRR_RESP_OKAY         2'h0
`define WRR_RESP_SLVERR       2'h2

`endif

// File: hw/wrr_entry_walker.v
// Entry pointer and message counter that walk the schedule table.
`timescale 1ns/1ps
`include "wrr_sched_regs.vh"

module wrr_entry_walker (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [3:0] entry_count,
  input  wire       queue_pending,
  input  wire       msg_taken,
  output wire [3:0] entry_index,
  output wire [3:0] msgs_done
);

  reg [3:0] entry_reg;
  reg [3:0] entry_next;
  reg [3:0] done_reg;
  reg [3:0] done_next;
  reg       finished;

  // ==========================================================================
  // Advance decision
  // ==========================================================================
  // An entry is finished when its count is used up, when it is zero, or when its
  // queue has nothing to send; skipping keeps an idle queue from stalling the table.
  always @* begin
    finished   = 1'b0;
    done_next  = done_reg;
    entry_next = entry_reg;
    if (entry_count == `WRR_COUNT_RESET || !queue_pending) begin
      finished = 1'b1;
    end else if (msg_taken) begin
      if (done_reg + 4'h1 == entry_count) begin
        finished = 1'b1;
      end else begin
        done_next = done_reg + 4'h1;
      end
    end
    if (finished) begin
      done_next  = 4'h0;
      entry_next = entry_reg + 4'h1;       // Wraps from 15 to 0.
    end
  end

  // The pointer starts at entry zero after reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      entry_reg <= 4'h0;
      done_reg  <= 4'h0;
    end else begin
      entry_reg <= entry_next;
      done_reg  <= done_next;
    end
  end

  assign entry_index = entry_reg;
  assign msgs_done   = done_reg;

endmodule // wrr_entry_walker

// File: hw/tx_queue_wrr_scheduler.v
// Weighted round-robin transmit queue scheduler with an AXI4-Lite register slave.
// Summary of operation
// - Sixteen schedule entries, each with a 4-bit selector naming one of sixteen queues.
// - Each entry has a 4-bit count; up to that many messages are taken before leaving, fewer if its queue empties.
// - After finishing an entry the scheduler moves to the next higher entry.
// - After entry fifteen the scheduler wraps to entry zero, forever.
// - Entries four to seven live at 07E4h, one byte each, selector low nibble.
// - Entries eight to eleven live at 07E8h; selectors reset to their own index.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wrr_sched_regs.vh"

module tx_queue_wrr_scheduler (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [15:0] queue_pending,
  output wire [3:0]  grant_queue,
  output wire        grant_valid,
  input  wire        grant_ready,
  output wire [3:0]  active_entry
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Maps a byte address to a table word index, or 3'h4 for status, 3'h7 if unmapped.
  function [2:0] word_sel;
    input [11:0] addr;
    begin
      case ({addr[11:2], 2'b00})
        `WRR_OFF_ENTRIES_0_3:   word_sel = 3'h0;
        `WRR_OFF_ENTRIES_4_7:   word_sel = 3'h1;
        `WRR_OFF_ENTRIES_8_11:  word_sel = 3'h2;
        `WRR_OFF_ENTRIES_12_15: word_sel = 3'h3;
        `WRR_OFF_STATUS:        word_sel = 3'h4;
        default:                word_sel = 3'h7;
      endcase
    end
  endfunction

  // ==========================================================================
  // Schedule table storage
  // ==========================================================================
  reg  [7:0]  table_reg [0:15];
  wire [3:0]  cur_entry;
  wire [3:0]  msgs_done;
  wire [7:0]  cur_byte;
  wire [3:0]  cur_qsel;
  wire [3:0]  cur_count;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  // Address and data are latched independently so the master may offer them
  // in either order; the response waits for both.
  reg        aw_held_reg;
  reg [11:0] aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  wire       do_write;
  wire [2:0] wsel;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wsel          = word_sel(aw_addr_reg);
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Channel capture and response generation.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `WRR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // Status is read-only; writes to it or to holes get an error answer.
        bresp_reg   <= (wsel[2]) ? `WRR_RESP_SLVERR : `WRR_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Table update
  // ==========================================================================
  // One byte lane per entry; selectors reset to their own index, counts to zero.
  genvar gi;
  generate
    for (gi = 0; gi < `WRR_NUM_ENTRIES; gi = gi + 1) begin : g_entry
      always @(posedge aclk) begin
        if (!aresetn) begin
          table_reg[gi] <= {`WRR_COUNT_RESET, gi[3:0]};
        end else if (do_write && wsel == gi[4:2] && w_strb_reg[gi % 4]) begin
          table_reg[gi] <= w_data_reg[(gi % 4) * 8 +: 8];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read channel
  // ==========================================================================
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  wire [2:0] rsel;
  reg [31:0] rword;

  assign rsel          = word_sel(s_axi_araddr);
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read multiplexer; status shows the walker's position and current grant.
  always @* begin
    rword = 32'h0000_0000;
    case (rsel)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        rword = {table_reg[{rsel[1:0], 2'b11}], table_reg[{rsel[1:0], 2'b10}],
                 table_reg[{rsel[1:0], 2'b01}], table_reg[{rsel[1:0], 2'b00}]};
      end
      3'h4: begin
        rword = {19'h00000, grant_valid, msgs_done, cur_qsel, cur_entry};
      end
      default: begin
        rword = 32'h0000_0000;
      end
    endcase
  end

  // Read answer register, one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `WRR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rword;
      rresp_reg  <= (rsel == 3'h7) ? `WRR_RESP_SLVERR : `WRR_RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Scheduling
  // ==========================================================================
  // The grant is offered combinationally from the current entry so a waiting
  // transmit engine sees it in the same cycle; the table itself is the source
  // of order and weight that software programs.
  assign cur_byte  = table_reg[cur_entry];
  assign cur_qsel  = cur_byte[`WRR_QSEL_LSB +: `WRR_QSEL_W];
  assign cur_count = cur_byte[`WRR_COUNT_LSB +: `WRR_COUNT_W];

  wire cur_pending;
  assign cur_pending  = queue_pending[cur_qsel];
  assign grant_valid  = cur_pending && (cur_count != `WRR_COUNT_RESET);
  assign grant_queue  = cur_qsel;
  assign active_entry = cur_entry;

  wrr_entry_walker u_walker (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .entry_count   (cur_count),
    .queue_pending (cur_pending),
    .msg_taken     (grant_valid && grant_ready),
    .entry_index   (cur_entry),
    .msgs_done     (msgs_done)
  );

endmodule // tx_queue_wrr_scheduler

// File: tb/wrr_sched_properties.sv
// Concurrent checks on the ports of the round-robin scheduler.
`timescale 1ns/1ps
module wrr_sched_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] queue_pending,
  input wire logic [3:0]  grant_queue,
  input wire logic        grant_valid,
  input wire logic        grant_ready,
  input wire logic [3:0]  active_entry
);
  // ==========================================================================
  // Properties; all share one clock and the reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  grant_src_a: assert property (grant_valid |-> queue_pending[grant_queue])
    else $error("grant offered for an empty queue");
  // The sampled reset keeps the edge that releases reset from expecting a step.
  skip_entry_a: assert property (aresetn && !grant_valid |=>
    active_entry == $past(active_entry) + 4'h1)
    else $error("idle entry was not skipped");
  wrap_zero_a: assert property (active_entry == 4'hF && !grant_valid |=>
    active_entry == 4'h0)
    else $error("pointer did not wrap to entry zero");
  hold_entry_a: assert property (grant_valid && !grant_ready |=> $stable(active_entry))
    else $error("entry left while a grant was pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during a response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during a response");
  write_close_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn");
  cover property (grant_valid && grant_ready);
  cover property (active_entry == 4'hF ##1 active_entry == 4'h0);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // wrr_sched_checker

bind tx_queue_wrr_scheduler wrr_sched_checker wrr_sched_checker_inst (.*);

// File: tb/tx_queue_partner.sv
// Behavioural model of the descriptor queues and the message sink.
`timescale 1ns/1ps
module tx_queue_partner (
  input  wire logic [1:0]  mode,
  input  wire logic        aclk,
  output logic      [15:0] queue_pending = 16'h0000,
  output logic             grant_ready = 1'b1
);
  integer seed = 32'h823A;
  // Mode 0 idle, 1 all queues full with a prompt sink, 2 queues that drain at random
  // and a sink that stalls, so entries get abandoned mid-count.
  logic [31:0] rnd = 32'h0000_0000;
  always @(posedge aclk) begin
    rnd           <= $random(seed);
    queue_pending <= (mode == 2'h0) ? 16'h0000 : (mode == 2'h1) ? 16'hFFFF : rnd[15:0];
    grant_ready   <= (mode == 2'h2) ? rnd[16] : 1'b1;
  end
endmodule // tx_queue_partner

// File: tb/tx_queue_wrr_scheduler_test.sv
// Self-checking bench for the round-robin scheduler and its register slave.
`timescale 1ns/1ps
`include "wrr_sched_regs.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tx_queue_wrr_scheduler_test;
  logic        aclk = 0, aresetn = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, v;
  logic [3:0]  s_axi_wstrb = 4'hF, exp_e, exp_d;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  tbl [16];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         grant_valid, grant_ready;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  grant_queue, active_entry;
  wire  [15:0] queue_pending;
  integer      seed = 32'h823A, err_total = 0, n_compared = 0, i, j;

  tx_queue_wrr_scheduler tx_queue_wrr_scheduler_inst (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .queue_pending (queue_pending),
    .grant_queue   (grant_queue),
    .grant_valid   (grant_valid),
    .grant_ready   (grant_ready),
    .active_entry  (active_entry));
  tx_queue_partner tx_queue_partner_inst (.mode(mode), .aclk(aclk),
    .queue_pending(queue_pending), .grant_ready(grant_ready));

  always #50 aclk = ~aclk;

  // Expected grant from the shadow table and the queue levels.
  function automatic logic exp_grant(input logic [3:0] e);
    return queue_pending[tbl[e][3:0]] && tbl[e][7:4] != 4'h0;
  endfunction

  // Reference walker; it sees the same pre-edge inputs as the design.
  always @(posedge aclk) begin
    if (!aresetn) begin
      exp_e = 4'h0;
      exp_d = 4'h0;
    end else if (exp_grant(exp_e) ? grant_ready && exp_d + 4'h1 == tbl[exp_e][7:4] : 1'b1) begin
      exp_e = exp_e + 4'h1;
      exp_d = 4'h0;
    end else if (grant_ready) begin
      exp_d = exp_d + 4'h1;
    end
  end

  // Outputs are compared mid-cycle, where they have settled.
  always @(negedge aclk) begin
    if (aresetn) begin
      `CHK("entry", exp_e, active_entry);
      `CHK("grant", exp_grant(exp_e), grant_valid);
      if (grant_valid === 1'b1) `CHK("queue", tbl[exp_e][3:0], grant_queue);
    end
  end

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Each channel is held until the edge at which its ready was seen high.
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    int k;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50 && !b; k++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    if (!b) begin
      err_total++;
      complete_run;
    end
    `CHK("bresp", er, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, rv;
    logic [31:0] d, es;
    logic [1:0] r;
    int k;
    rv = 0;
    es = 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50 && !rv; k++) begin
      @(negedge aclk);
      t = s_axi_arready;
      // Status expected from the model state that the taking edge will see.
      if (t === 1'b1) es = {19'h0, exp_grant(exp_e), exp_d, tbl[exp_e][3:0], exp_e};
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'b0;
    end
    if (!rv) begin
      err_total++;
      complete_run;
    end
    `CHK("rdata", (a == `WRR_OFF_STATUS) ? es : ed, d);
    `CHK("rresp", er, r);
  endtask

  // Unmapped accesses, reset values, random table with corner counts, then traffic.
  initial begin
    for (i = 0; i < 16; i++) tbl[i] = {4'h0, i[3:0]};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(12'h7F8, 32'hFFFFFFFF, `WRR_RESP_SLVERR);
    wr(`WRR_OFF_STATUS, 32'hFFFFFFFF, `WRR_RESP_SLVERR);
    rd(12'h7F4, 32'h0, `WRR_RESP_SLVERR);
    rd(`WRR_OFF_STATUS, 32'h0, `WRR_RESP_OKAY);
    for (i = 0; i < 4; i++) rd(12'(`WRR_OFF_ENTRIES_0_3 + 4 * i),
      32'h03020100 + 32'h04040404 * i, `WRR_RESP_OKAY);
    $display("test reset_values done");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i == 0) v[7:4] = 4'h0;
      if (i == 3) v[31:28] = 4'hF;
      wr(12'(`WRR_OFF_ENTRIES_0_3 + 4 * i), v, `WRR_RESP_OKAY);
      rd(12'(`WRR_OFF_ENTRIES_0_3 + 4 * i), v, `WRR_RESP_OKAY);
      for (j = 0; j < 4; j++) tbl[4 * i + j] = v[8 * j +: 8];
    end
    // Partial strobe: only entries four and six may change.
    v = $random(seed);
    s_axi_wstrb <= 4'h5;
    wr(`WRR_OFF_ENTRIES_4_7, v, `WRR_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    tbl[4] = v[7:0];
    tbl[6] = v[23:16];
    rd(`WRR_OFF_ENTRIES_4_7, {tbl[7], tbl[6], tbl[5], tbl[4]}, `WRR_RESP_OKAY);
    $display("test table_program done");
    mode <= 2'h1;
    repeat (400) @(posedge aclk);
    rd(`WRR_OFF_STATUS, 32'h0, `WRR_RESP_OKAY);
    repeat (400) @(posedge aclk);
    $display("test full_queues done");
    mode <= 2'h2;
    repeat (1000) @(posedge aclk);
    rd(`WRR_OFF_STATUS, 32'h0, `WRR_RESP_OKAY);
    repeat (1000) @(posedge aclk);
    $display("test random_queues done");
    complete_run;
  end
endmodule // tx_queue_wrr_scheduler_test
